/* ext_irq_front.sv */
// External interrupt front end: filters, triggers, latches, AHB regs
`timescale 1ns/1ps

// Summary of operation
// - Captured level reads zero after reset, else level
// - Captured level refreshed on every input 4 request
// - Input 4 trigger: rise, fall, both, high level
// - High-speed input 4 interval: divide by 1,4,8,16
// - Low-speed sampling at low clock divided by four
// - Control bits 7 to 5 read zero
// - Inputs 0 and 5 falling edge, short filter
// - Inputs 1 to 4 high-speed filter width
// - Clock gate off stops all requests
// - Clock gate is off after reset
// - High speed needs three agreeing samples on inputs 1 to 4
// - Low speed needs two agreeing samples
// - Deep idle, deep sleep, stop halt sampling
module ext_irq_front (
    input wire logic CLK_I,            // 100 MHz gear clock
    input wire logic RSTN_I,           // Async reset, active low
    input wire logic CE_I,             // Clock enable, freezes all
    input wire logic HSEL_I,           // AHB select
    input wire logic [31:0] HADDR_I,   // AHB address
    input wire logic [1:0] HTRANS_I,   // AHB transfer type
    input wire logic HWRITE_I,         // AHB write
    input wire logic [2:0] HSIZE_I,    // AHB size
    input wire logic [31:0] HWDATA_I,  // AHB write data
    input wire logic HREADY_I,         // AHB bus ready
    output logic HREADYOUT_O,          // AHB slave ready
    output logic [31:0] HRDATA_O,      // AHB read data
    output logic HRESP_O,              // AHB response, always OKAY
    input wire logic [5:0] PIN_I,      // Interrupt pins 0 to 5
    input wire logic LFCLK_I,          // Low-frequency clock level
    input wire logic [2:0] MODE_I,     // Operating mode code
    output logic [5:0] IRQ_O           // Enabled pending requests
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic reg_hit(input logic [31:0] a,
                                     input logic [29:0] idx);
        reg_hit = (a[31:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic tick_sel(input logic [1:0] intv,
                                      input logic [3:0] p);
        case (intv)
            ext_irq_pkg::INTV_DIV1: tick_sel = 1'b1;
            ext_irq_pkg::INTV_DIV4: tick_sel = &p[1:0];
            ext_irq_pkg::INTV_DIV8: tick_sel = &p[2:0];
            default: tick_sel = &p;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Registers and state
    // ----------------------------------------------------------------
    ext_irq_pkg::ctrl4_t ctrl_reg;
    ext_irq_pkg::ahb_addr_t aph_reg;
    ext_irq_pkg::bus_state_t bus_reg;
    logic gate_reg;
    logic master_reg;
    logic [5:0] en_reg;
    logic [5:0] pend_reg;
    logic [5:0] pend_next;
    logic [5:0] pin_reg;
    logic [5:0] prev_reg;
    logic [5:0] irq_reg;
    logic [31:0] rdata_reg;
    logic hready_reg;
    logic lf_prev_reg;
    logic [1:0] lf_cnt_reg;
    logic [3:0] presc_reg;
    logic [5:0] filt;
    logic [5:0] ev;
    logic [5:0] clr;
    logic [5:0] hs_tick;
    logic [7:0] ctrl_rd;
    logic ls_mode;
    logic hs_mode;
    logic act;
    logic ls_tick;
    logic lf_rise;
    logic addr_take;
    logic wr_now;
    logic rd_now;

    // ----------------------------------------------------------------
    // Mode decode and sampling strobes
    // ----------------------------------------------------------------
    assign hs_mode = (MODE_I == ext_irq_pkg::MODE_HS_RUN)
                  || (MODE_I == ext_irq_pkg::MODE_HS_IDLE);
    assign ls_mode = (MODE_I == ext_irq_pkg::MODE_LS_RUN)
                  || (MODE_I == ext_irq_pkg::MODE_LS_SLEEP);
    // Deep modes and a closed gate stop sampling and events
    assign act = gate_reg && (hs_mode || ls_mode);

    assign lf_rise = LFCLK_I && !lf_prev_reg;
    assign ls_tick = CE_I && lf_rise
                  && (lf_cnt_reg == ext_irq_pkg::LF_DIV_LAST);

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            lf_prev_reg <= 1'b0;
            lf_cnt_reg <= 2'h0;
        end else if (CE_I) begin
            lf_prev_reg <= LFCLK_I;
            if (lf_rise && act) begin
                lf_cnt_reg <= lf_cnt_reg + 2'h1;
            end
        end
    end

    // One prescaler shared by all taps keeps the strobes aligned
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            presc_reg <= 4'h0;
        end else if (CE_I && act) begin
            presc_reg <= presc_reg + 4'h1;
        end
    end

    // Inputs 0 to 3 and 5 sample at every gear clock
    assign hs_tick[3:0] = 4'hf;
    assign hs_tick[5] = 1'b1;
    assign hs_tick[4] = CE_I && tick_sel(ctrl_reg.intv, presc_reg);

    // ----------------------------------------------------------------
    // Pin sampling and noise cancellers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pin_reg <= 6'h00;
        end else if (CE_I && act) begin
            pin_reg <= PIN_I;
        end
    end

    for (genvar i = 0; i < 6; i++) begin : g_filt
        logic [1:0] need;
        logic tick;
        // In high-speed modes fixed inputs need two gear-clock samples, the rest three; low speed needs two for all
        assign need = ls_mode ? ext_irq_pkg::LS_AGREE :
                      ((i == 0 || i == 5) ? ext_irq_pkg::FIX_AGREE
                                          : ext_irq_pkg::HS_AGREE);
        assign tick = ls_mode ? ls_tick : hs_tick[i];
        noise_filter u_filt (
            .clk_i(CLK_I),
            .rstn_i(RSTN_I),
            .ce_i(CE_I),
            .run_i(act),
            .tick_i(tick),
            .need_i(need),
            .din_i(pin_reg[i]),
            .level_o(filt[i])
        );
    end

    // ----------------------------------------------------------------
    // Trigger detection and pending latch
    // ----------------------------------------------------------------
    always_comb begin
        ev = (prev_reg & ~filt) & {6{act}};
        case (ctrl_reg.sel)
            ext_irq_pkg::TRIG_RISE: ev[4] = act && filt[4] && !prev_reg[4];
            ext_irq_pkg::TRIG_FALL: ev[4] = act && !filt[4] && prev_reg[4];
            ext_irq_pkg::TRIG_BOTH: ev[4] = act && (filt[4] != prev_reg[4]);
            default: ev[4] = act && filt[4];
        endcase
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            prev_reg <= 6'h00;
        end else if (CE_I && act) begin
            prev_reg <= filt;
        end
    end

    assign clr = wr_now && reg_hit(aph_reg.addr, ext_irq_pkg::IDX_PEND)
               ? HWDATA_I[5:0] : 6'h00;
    // A request in the same cycle as its clear stays pending
    assign pend_next = (pend_reg & ~clr) | ev;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pend_reg <= ext_irq_pkg::PEND_RST;
        end else if (CE_I) begin
            pend_reg <= pend_next;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            irq_reg <= 6'h00;
        end else if (CE_I) begin
            irq_reg <= pend_reg & en_reg & {6{master_reg}};
        end
    end
    assign IRQ_O = irq_reg;

    // ----------------------------------------------------------------
    // AHB-Lite slave, one wait state on every transfer
    // ----------------------------------------------------------------
    assign addr_take = HSEL_I && HTRANS_I[1] && HREADY_I
                    && (bus_reg == ext_irq_pkg::BUS_ADDR);
    assign wr_now = CE_I && (bus_reg == ext_irq_pkg::BUS_DATA)
                 && aph_reg.write && aph_reg.word;
    assign rd_now = CE_I && (bus_reg == ext_irq_pkg::BUS_DATA)
                 && !aph_reg.write;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            bus_reg <= ext_irq_pkg::BUS_ADDR;
            hready_reg <= 1'b1;
            aph_reg <= '0;
        end else if (CE_I) begin
            case (bus_reg)
                ext_irq_pkg::BUS_ADDR: begin
                    if (addr_take) begin
                        aph_reg.addr <= HADDR_I;
                        aph_reg.write <= HWRITE_I;
                        aph_reg.word <= (HSIZE_I == ext_irq_pkg::HSIZE_WORD);
                        bus_reg <= ext_irq_pkg::BUS_DATA;
                        hready_reg <= 1'b0;
                    end
                end
                default: begin
                    bus_reg <= ext_irq_pkg::BUS_ADDR;
                    hready_reg <= 1'b1;
                end
            endcase
        end
    end

    // Software registers; the captured level tracks each request
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl_reg <= ext_irq_pkg::CTRL4_RST;
            gate_reg <= ext_irq_pkg::GATE_RST;
            {master_reg, en_reg} <= ext_irq_pkg::ENABLE_RST;
        end else if (CE_I) begin
            if (ev[4]) begin
                ctrl_reg.lvl <= filt[4];
            end
            if (wr_now) begin
                if (reg_hit(aph_reg.addr, ext_irq_pkg::IDX_CTRL4)) begin
                    ctrl_reg.sel <= HWDATA_I[ext_irq_pkg::CTRL_SEL_LSB +: 2];
                    ctrl_reg.intv <= HWDATA_I[ext_irq_pkg::CTRL_INT_LSB +: 2];
                end else if (reg_hit(aph_reg.addr,
                                     ext_irq_pkg::IDX_GATE)) begin
                    gate_reg <= HWDATA_I[ext_irq_pkg::GATE_BIT];
                end else if (reg_hit(aph_reg.addr,
                                     ext_irq_pkg::IDX_ENABLE)) begin
                    master_reg <= HWDATA_I[ext_irq_pkg::MASTER_BIT];
                    en_reg <= HWDATA_I[5:0];
                end
            end
        end
    end

    assign ctrl_rd = {3'h0, ctrl_reg};

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rdata_reg <= 32'h00000000;
        end else if (rd_now) begin
            if (reg_hit(aph_reg.addr, ext_irq_pkg::IDX_CTRL4)) begin
                rdata_reg <= {24'h000000, ctrl_rd};
            end else if (reg_hit(aph_reg.addr, ext_irq_pkg::IDX_GATE)) begin
                rdata_reg <= {31'h00000000, gate_reg};
            end else if (reg_hit(aph_reg.addr, ext_irq_pkg::IDX_ENABLE)) begin
                rdata_reg <= {24'h000000, master_reg, 1'b0, en_reg};
            end else if (reg_hit(aph_reg.addr, ext_irq_pkg::IDX_PEND)) begin
                rdata_reg <= {26'h0000000, pend_reg};
            end else if (reg_hit(aph_reg.addr, ext_irq_pkg::IDX_LEVEL)) begin
                rdata_reg <= {26'h0000000, filt};
            end else begin
                rdata_reg <= 32'h00000000;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            HRESP_O <= 1'b0;
        end else if (CE_I) begin
            HRESP_O <= 1'b0;
        end
    end

    assign HREADYOUT_O = hready_reg;
    assign HRDATA_O = rdata_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_lvl_capture: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && ev[4] |=> ctrl_reg.lvl == $past(filt[4]))
        else $error("captured level not refreshed on request");

    a_lvl_stable: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        !ev[4] |=> $stable(ctrl_reg.lvl))
        else $error("captured level moved without a request");

    a_rise_trigger: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && act && ctrl_reg.sel == 2'h0 && filt[4] && !prev_reg[4]
        |=> pend_reg[4])
        else $error("rising edge did not set pending");

    // A mode change away from high level ends the obligation
    a_high_level: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && act && ctrl_reg.sel == 2'h3 && filt[4]
        ##1 CE_I && ctrl_reg.sel == 2'h3
        |-> pend_reg[4] && ev[4] == (act && filt[4]))
        else $error("high level did not keep requesting");

    a_div16_spacing: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        hs_tick[4] && ctrl_reg.intv == 2'h3 && act
        ##1 (ctrl_reg.intv == 2'h3 && act && CE_I)
        |-> !hs_tick[4])
        else $error("divide-by-16 strobe came too soon");

    a_irq_gate: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        (IRQ_O & ~$past(IRQ_O)) != 6'h00 |-> $past(master_reg)
        && (IRQ_O & ~$past(IRQ_O) & ~$past(en_reg)) == 6'h00)
        else $error("request passed without both enables");

    a_rsvd_zero: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        rd_now && reg_hit(aph_reg.addr, ext_irq_pkg::IDX_CTRL4)
        |=> HRDATA_O[7:5] == 3'h0 && HREADYOUT_O)
        else $error("control register unused bits not zero");

    a_gate_blocks: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        CE_I && !act |=> (pend_reg & ~$past(pend_reg)) == 6'h00)
        else $error("request set while gated or halted");

    a_ls_tick_gap: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        ls_tick |-> !lf_prev_reg && lf_cnt_reg == ext_irq_pkg::LF_DIV_LAST
        ##1 !ls_tick)
        else $error("low-speed strobe not a quarter of edges");

endmodule

/* ext_irq_pkg.sv */
// Constants and types shared by the external interrupt front end
package ext_irq_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [29:0] IDX_CTRL4 = 30'h00000fdb;
    localparam logic [29:0] IDX_GATE = 30'h00000fd0;
    localparam logic [29:0] IDX_ENABLE = 30'h00000fd1;
    localparam logic [29:0] IDX_PEND = 30'h00000fd2;
    localparam logic [29:0] IDX_LEVEL = 30'h00000fd3;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_LVL_BIT = 4;
    localparam int CTRL_SEL_LSB = 2;
    localparam int CTRL_INT_LSB = 0;
    localparam int GATE_BIT = 0;
    localparam int MASTER_BIT = 7;
    localparam logic [4:0] CTRL4_RST = 5'h00;
    localparam logic GATE_RST = 1'b0;
    localparam logic [6:0] ENABLE_RST = 7'h00;
    localparam logic [5:0] PEND_RST = 6'h00;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ----------------------------------------------------------------
    // Timing: clock rate, dividers and agreeing-sample counts
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [1:0] LF_DIV_LAST = 2'h3;
    localparam logic [1:0] HS_AGREE = 2'h3;
    localparam logic [1:0] LS_AGREE = 2'h2;
    localparam logic [1:0] FIX_AGREE = 2'h2;

    // ----------------------------------------------------------------
    // Operating modes, trigger and interval codes
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_HS_RUN = 3'h0;
    localparam logic [2:0] MODE_HS_IDLE = 3'h1;
    localparam logic [2:0] MODE_LS_RUN = 3'h2;
    localparam logic [2:0] MODE_LS_SLEEP = 3'h3;
    localparam logic [2:0] MODE_DEEP_IDLE = 3'h4;
    localparam logic [2:0] MODE_DEEP_SLEEP = 3'h5;
    localparam logic [2:0] MODE_STOP = 3'h6;
    localparam logic [1:0] TRIG_RISE = 2'h0;
    localparam logic [1:0] TRIG_FALL = 2'h1;
    localparam logic [1:0] TRIG_BOTH = 2'h2;
    localparam logic [1:0] TRIG_HIGH = 2'h3;
    localparam logic [1:0] INTV_DIV1 = 2'h0;
    localparam logic [1:0] INTV_DIV4 = 2'h1;
    localparam logic [1:0] INTV_DIV8 = 2'h2;
    localparam logic [1:0] INTV_DIV16 = 2'h3;

    typedef struct packed {
        logic lvl;
        logic [1:0] sel;
        logic [1:0] intv;
    } ctrl4_t;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic word;
    } ahb_addr_t;

    typedef enum logic [1:0] {
        BUS_ADDR = 2'b01,
        BUS_DATA = 2'b10
    } bus_state_t;

endpackage

/* noise_filter.sv */
// Sample-agreement noise canceller for one interrupt pin
`timescale 1ns/1ps
module noise_filter (
    input wire logic clk_i,       // Gear clock
    input wire logic rstn_i,      // Async reset, active low
    input wire logic ce_i,        // Clock enable
    input wire logic run_i,       // Sampling allowed
    input wire logic tick_i,      // Sampling strobe
    input wire logic [1:0] need_i, // Agreeing samples needed
    input wire logic din_i,       // Sampled pin level
    output logic level_o          // Filtered level
);
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic level_reg;
    logic take;

    assign cnt_next = cnt_reg + 2'h1;
    assign take = ce_i && run_i && tick_i;
    assign level_o = level_reg;

    // A differing sample run is only accepted once it is long enough;
    // any agreeing sample in between starts the count over.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 2'h0;
            level_reg <= 1'b0;
        end else if (take) begin
            if (din_i == level_reg) begin
                cnt_reg <= 2'h0;
            end else if (cnt_next >= need_i) begin
                level_reg <= din_i;
                cnt_reg <= 2'h0;
            end else begin
                cnt_reg <= cnt_next;
            end
        end
    end

    logic acc_hit;
    assign acc_hit = take && din_i != level_reg && cnt_next >= need_i;

    a_filter_agree: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (level_reg != $past(level_reg)) |-> $past(acc_hit))
        else $error("filtered level changed without enough samples");

    a_filter_hold: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !run_i |=> $stable(level_reg))
        else $error("filter moved while sampling halted");

endmodule

/* pin_source.sv */
// Model of the external sources that drive the six interrupt pins
`timescale 1ns/1ps
module pin_source (
    input wire logic clk_i,    // Gear clock
    input wire logic rstn_i,   // Async reset, active low
    output logic [5:0] pin_o,  // Pin levels, idle high
    output logic lfclk_o       // Low-frequency clock level
);
    logic [1:0] div_reg;
    // Low clock runs free at a quarter of the gear clock, which keeps
    // the low-speed filter windows short in simulation
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end
    assign lfclk_o = div_reg[1];
    initial pin_o = 6'h3f;
    task set_level(input int n, input logic v);
        pin_o[n] <= v;
    endtask
    task pulse(input int n, input int w);
        pin_o[n] <= 1'b0;
        repeat (w) @(posedge clk_i);
        pin_o[n] <= 1'b1;
    endtask
endmodule

/* tb.sv */
// Testbench for the external interrupt front end
`timescale 1ns/1ps
module tb;
    localparam logic [29:0] C4 = ext_irq_pkg::IDX_CTRL4;
    localparam logic [29:0] GT = ext_irq_pkg::IDX_GATE;
    localparam logic [29:0] EN = ext_irq_pkg::IDX_ENABLE;
    localparam logic [29:0] PD = ext_irq_pkg::IDX_PEND;
    localparam logic [29:0] LV = ext_irq_pkg::IDX_LEVEL;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] mode = ext_irq_pkg::MODE_HS_RUN;
    logic ce = 1'b1;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic [5:0] pin;
    logic lfclk;
    logic [5:0] irq;
    // Expected pending bit of pin 4 per trigger code, after rise,
    // after clear while high, after fall; and captured level at the end
    logic [3:0] er = 4'b1101;
    logic [3:0] eh = 4'b1000;
    logic [3:0] ef = 4'b1110;
    logic [3:0] el = 4'b1001;
    int fail_count = 0;
    int total_checks = 0;
    int d;
    always #5 clk = ~clk;
    pin_source src (.clk_i(clk), .rstn_i(rstn), .pin_o(pin), .lfclk_o(lfclk));
    ext_irq_front dut (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HREADYOUT_O(hready), .HRDATA_O(hrdata),
        .HRESP_O(hresp), .PIN_I(pin), .LFCLK_I(lfclk), .MODE_I(mode),
        .IRQ_O(irq));
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task conclude();
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wait_ready();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail_count++;
                $display("CHECK FAILED at %0t: bus timeout", $time);
                conclude();
            end
            @(posedge clk);
        end
    endtask
    task bus(input logic w, input logic [29:0] idx, input logic [31:0] wd,
             output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {idx, 2'h0};
        hwrite <= w;
        hsize <= ext_irq_pkg::HSIZE_WORD;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task wr(input logic [29:0] idx, input logic [31:0] wd);
        logic [31:0] unused;
        bus(1'b1, idx, wd, unused);
    endtask
    task rd(input logic [29:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, idx, 32'h0, v);
        check(v, exp);
        check({31'h0, hresp}, 32'h0);
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        tick(3);
        rstn <= 1'b1;
        tick(1);
        rd(GT, 32'h0);
        rd(C4, 32'h0);
        src.pulse(0, 5);
        tick(20);
        rd(PD, 32'h0);
        rd(LV, 32'h0);
        wr(GT, 32'h1);
        tick(10);
        wr(PD, 32'h3f);
        rd(LV, 32'h3f);
        wr(EN, 32'h3f);
        src.pulse(0, 5);
        tick(10);
        check({26'h0, irq}, 32'h0);
        rd(PD, 32'h1);
        wr(EN, 32'hbf);
        tick(3);
        check({26'h0, irq}, 32'h1);
        wr(EN, 32'h0);
        wr(PD, 32'h3f);
        for (int p = 0; p < 6; p++) begin
            if (p != 4) begin
                src.pulse(p, (p % 5 == 0) ? 1 : 2);
                tick(20);
                rd(PD, 32'h0);
                src.pulse(p, (p % 5 == 0) ? 3 : 5);
                tick(20);
                rd(PD, 32'h1 << p);
                wr(PD, 32'h3f);
            end
        end
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 1 : (2 << k);
            wr(C4, {28'h0, 2'h1, k[1:0]});
            wr(PD, 32'h3f);
            src.pulse(4, 2 * d - 1);
            tick(100);
            rd(PD, 32'h0);
            src.pulse(4, 4 * d + 1);
            tick(100);
            rd(PD, 32'h10);
        end
        wr(C4, 32'h0);
        src.set_level(4, 1'b0);
        tick(20);
        for (int s = 0; s < 4; s++) begin
            wr(C4, {24'h0, 3'h7, 1'b0, s[1:0], 2'h0});
            wr(PD, 32'h3f);
            rd(PD, 32'h0);
            src.set_level(4, 1'b1);
            tick(20);
            rd(PD, {27'h0, er[s], 4'h0});
            rd(C4, {27'h0, 1'b1, s[1:0], 2'h0});
            wr(PD, 32'h3f);
            tick(3);
            rd(PD, {27'h0, eh[s], 4'h0});
            src.set_level(4, 1'b0);
            tick(20);
            rd(PD, {27'h0, ef[s], 4'h0});
            rd(C4, {27'h0, el[s], s[1:0], 2'h0});
        end
        wr(PD, 32'h3f);
        mode <= ext_irq_pkg::MODE_LS_RUN;
        tick(48);
        wr(PD, 32'h3f);
        src.pulse(0, 15);
        tick(100);
        rd(PD, 32'h0);
        mode <= ext_irq_pkg::MODE_LS_SLEEP;
        src.pulse(0, 40);
        tick(100);
        rd(PD, 32'h1);
        wr(PD, 32'h3f);
        for (int m = 4; m < 7; m++) begin
            mode <= m[2:0];
            tick(5);
            src.pulse(0, 40);
            tick(100);
        end
        rd(PD, 32'h0);
        mode <= ext_irq_pkg::MODE_HS_IDLE;
        tick(5);
        wr(PD, 32'h3f);
        src.pulse(5, 3);
        tick(20);
        rd(PD, 32'h20);
        wr(PD, 32'h3f);
        // A pulse while the clock enable is low must leave no trace
        ce <= 1'b0;
        src.pulse(5, 5);
        tick(3);
        ce <= 1'b1;
        tick(20);
        rd(PD, 32'h0);
        wr(GT, 32'h0);
        src.pulse(0, 5);
        tick(20);
        rd(PD, 32'h0);
        rd(30'h0, 32'h0);
        conclude();
    end
endmodule
